// file: include/evmon_pkg.sv
package evmon_pkg;
  localparam int NUM_SLOTS = 8;
  localparam int SLOT_W = 3;
  localparam int QUEUE_DEPTH = 4;
  localparam int QPTR_W = 2;
  localparam int NUM_EVENTS = 7;

  localparam logic [15:0] CMD_SET_ASSOC = 16'h8C00;
  localparam logic [15:0] CMD_GET_ASSOC = 16'h8C01;

  // byte lanes of the 32-bit parameter word
  localparam int BYTE_SLOT = 0;
  localparam int BYTE_FLAG = 1;
  localparam int BYTE_SEQ = 2;
  localparam int BYTE_EVENT = 3;

  localparam logic [7:0] EVENT_LAST = 8'h06;

  localparam logic [3:0] ADDR_COMMAND = 4'h0;
  localparam logic [3:0] ADDR_PARAM = 4'h1;
  localparam logic [3:0] ADDR_RESULT = 4'h2;
  localparam logic [3:0] ADDR_RESPONSE = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h5;
  localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h6;
  localparam logic [3:0] ADDR_ENGINE = 4'h7;

  localparam int IRQ_BITS = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_DROP = 1;
  localparam int IRQ_START = 2;

  typedef enum logic [2:0]
  {
    STATUS_OK = 3'b000,
    STATUS_INVALID_ARGUMENT = 3'b001,
    STATUS_NO_ENTRY = 3'b010,
    STATUS_SLOT_BUSY = 3'b011,
    STATUS_ALREADY_IN_USE = 3'b100,
    STATUS_OUT_OF_RANGE = 3'b101,
    STATUS_UNKNOWN_COMMAND = 3'b110
  } status_t;

  typedef struct packed
  {
    logic used;
    logic enabled;
    logic [7:0] seq_id;
    logic [7:0] system_event_code;
  } assoc_t;

  typedef struct packed
  {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef enum logic [1:0]
  {
    ENG_IDLE = 2'b00,
    ENG_SCAN = 2'b01,
    ENG_WAIT = 2'b10
  } eng_state_t;
endpackage

// file: hdl/event_sequence_association.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: enabled association on event starts its sequence
// R2: all matching slots run, ascending from zero
// R3: events during handling wait in queue
// R4: queue drains in order; full drops events
// R5: event code eight bits, values 0..6
// R6: code 0x8C00 is set association
// R7: code 0x8C01 reads back a slot
// R8: set bytes: slot, enable, sequence, event
// R9: disable of empty slot gives no-entry
// R10: disabled slot still running gives busy
// R11: enable of occupied slot gives already-in-use
// R12: sequence identifier accepted without checks
// R13: table updated before result is reported
// R14: get carries slot index at byte zero
// R15: get response: slot, enable, sequence, event
// R16: bad slot invalid-argument, bad event out-of-range
module event_sequence_association
  import evmon_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic event_valid_i,
  input wire logic [7:0] event_code_i,
  output logic seq_start_o,
  output logic [7:0] seq_id_o,
  input wire logic seq_done_i,
  output logic irq_o
);
  bus_req_t bus;
  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  assoc_t table_reg [NUM_SLOTS];
  logic [31:0] param_reg;
  status_t result_reg;
  logic [31:0] response_reg;
  logic [IRQ_BITS-1:0] irq_status_reg;
  logic [IRQ_BITS-1:0] irq_enable_reg;
  logic [7:0] queue_reg [QUEUE_DEPTH];
  logic [QPTR_W-1:0] qrd_reg;
  logic [QPTR_W-1:0] qwr_reg;
  logic [QPTR_W:0] qcount_reg;
  eng_state_t state_reg;
  logic [7:0] cur_event_reg;
  logic [SLOT_W:0] scan_reg;
  logic [SLOT_W-1:0] run_slot_reg;

  function automatic logic [7:0] param_byte(input logic [31:0] w, input int idx);
    param_byte = w[idx*8 +: 8];
  endfunction

  // command decode against the parameter word
  logic cmd_set;
  logic cmd_get;
  logic [7:0] p_slot;
  logic p_enable;
  logic [7:0] p_event;
  logic [SLOT_W-1:0] slot_idx;
  logic slot_running;
  status_t set_status;
  assign cmd_set = bus.wr && bus.addr == ADDR_COMMAND && bus.wdata[15:0] == CMD_SET_ASSOC; // R6
  assign cmd_get = bus.wr && bus.addr == ADDR_COMMAND && bus.wdata[15:0] == CMD_GET_ASSOC; // R7
  assign p_slot = param_byte(param_reg, BYTE_SLOT); // R8 R14
  assign p_enable = param_byte(param_reg, BYTE_FLAG) != 8'h00;
  assign p_event = param_byte(param_reg, BYTE_EVENT);
  assign slot_idx = p_slot[SLOT_W-1:0];
  assign slot_running = state_reg == ENG_WAIT && run_slot_reg == slot_idx;

  always_comb
  begin
    if (p_slot >= 8'(NUM_SLOTS))
      set_status = STATUS_INVALID_ARGUMENT; // R16
    else if (p_enable && p_event > EVENT_LAST)
      set_status = STATUS_OUT_OF_RANGE; // R16 R5
    else if (slot_running && !table_reg[slot_idx].enabled)
      set_status = STATUS_SLOT_BUSY; // R10
    else if (!p_enable && !table_reg[slot_idx].used)
      set_status = STATUS_NO_ENTRY; // R9
    else if (p_enable && table_reg[slot_idx].used)
      set_status = STATUS_ALREADY_IN_USE; // R11
    else
      set_status = STATUS_OK;
  end

  // table writes land in the same edge as the result, so a read sees both
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < NUM_SLOTS; i++)
        table_reg[i] <= '0;
    end
    else if (cmd_set && set_status == STATUS_OK)
    begin
      if (p_enable)
      begin
        // sequence id stored as given
        table_reg[slot_idx] <= '{used: 1'b1, enabled: 1'b1,
          seq_id: param_byte(param_reg, BYTE_SEQ), system_event_code: p_event}; // R12 R13
      end
      else
      begin
        table_reg[slot_idx] <= '0; // R13
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      param_reg <= '0;
    else if (bus.wr && bus.addr == ADDR_PARAM)
      param_reg <= bus.wdata;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      result_reg <= STATUS_OK;
      response_reg <= '0;
    end
    else if (cmd_set)
    begin
      result_reg <= set_status;
    end
    else if (cmd_get)
    begin
      if (p_slot >= 8'(NUM_SLOTS))
      begin
        result_reg <= STATUS_INVALID_ARGUMENT; // R16
        response_reg <= '0;
      end
      else
      begin
        result_reg <= STATUS_OK;
        response_reg <= {table_reg[slot_idx].system_event_code, table_reg[slot_idx].seq_id,
          7'h00, table_reg[slot_idx].enabled, p_slot}; // R15
      end
    end
    else if (bus.wr && bus.addr == ADDR_COMMAND)
    begin
      result_reg <= STATUS_UNKNOWN_COMMAND;
    end
  end

  // pending-event queue
  logic q_full;
  logic q_empty;
  logic ev_in;
  logic push;
  logic pop;
  assign q_full = qcount_reg == (QPTR_W+1)'(QUEUE_DEPTH);
  assign q_empty = qcount_reg == '0;
  assign ev_in = event_valid_i && event_code_i <= EVENT_LAST; // R5
  assign push = ev_in && !q_full; // R3 R4
  assign pop = state_reg == ENG_IDLE && !q_empty;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      qrd_reg <= '0;
      qwr_reg <= '0;
      qcount_reg <= '0;
      for (int i = 0; i < QUEUE_DEPTH; i++)
        queue_reg[i] <= '0;
    end
    else
    begin
      if (push)
      begin
        queue_reg[qwr_reg] <= event_code_i;
        qwr_reg <= qwr_reg + 1'b1;
      end
      if (pop)
        qrd_reg <= qrd_reg + 1'b1; // R4
      if (push && !pop)
        qcount_reg <= qcount_reg + 1'b1;
      else if (pop && !push)
        qcount_reg <= qcount_reg - 1'b1;
    end
  end

  // dispatch engine: one slot per cycle, waits for each sequence to finish
  logic hit;
  assign hit = scan_reg < (SLOT_W+1)'(NUM_SLOTS)
    && table_reg[scan_reg[SLOT_W-1:0]].enabled
    && table_reg[scan_reg[SLOT_W-1:0]].system_event_code == cur_event_reg;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= ENG_IDLE;
      cur_event_reg <= '0;
      scan_reg <= '0;
      run_slot_reg <= '0;
      seq_start_o <= 1'b0;
      seq_id_o <= '0;
    end
    else
    begin
      seq_start_o <= 1'b0;
      case (state_reg)
        ENG_IDLE:
        begin
          if (pop)
          begin
            cur_event_reg <= queue_reg[qrd_reg];
            scan_reg <= '0; // R2
            state_reg <= ENG_SCAN;
          end
        end
        ENG_SCAN:
        begin
          if (scan_reg >= (SLOT_W+1)'(NUM_SLOTS))
            state_reg <= ENG_IDLE; // R3
          else if (hit)
          begin
            seq_start_o <= 1'b1; // R1
            seq_id_o <= table_reg[scan_reg[SLOT_W-1:0]].seq_id;
            run_slot_reg <= scan_reg[SLOT_W-1:0];
            state_reg <= ENG_WAIT;
          end
          else
            scan_reg <= scan_reg + 1'b1; // R2
        end
        ENG_WAIT:
        begin
          if (seq_done_i)
          begin
            scan_reg <= scan_reg + 1'b1;
            state_reg <= ENG_SCAN;
          end
        end
        default:
          state_reg <= ENG_IDLE;
      endcase
    end
  end

  // interrupts: set wins over a clear in the same cycle
  logic [IRQ_BITS-1:0] irq_set;
  logic [IRQ_BITS-1:0] irq_clr;
  always_comb
  begin
    irq_set = '0;
    irq_set[IRQ_DONE] = cmd_set || cmd_get;
    irq_set[IRQ_DROP] = ev_in && q_full; // R4
    irq_set[IRQ_START] = state_reg == ENG_SCAN && hit;
    irq_clr = (bus.wr && bus.addr == ADDR_IRQ_CLEAR) ? bus.wdata[IRQ_BITS-1:0] : '0;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_status_reg <= '0;
    else
      irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_enable_reg <= '0;
    else if (bus.wr && bus.addr == ADDR_IRQ_ENABLE)
      irq_enable_reg <= bus.wdata[IRQ_BITS-1:0];
  end

  assign irq_o = |(irq_status_reg & irq_enable_reg);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= '0;
    else if (bus.rd)
    begin
      case (bus.addr)
        ADDR_PARAM: rdata_o <= param_reg;
        ADDR_RESULT: rdata_o <= {29'h0000_0000, result_reg};
        ADDR_RESPONSE: rdata_o <= response_reg;
        ADDR_IRQ_STATUS: rdata_o <= {29'h0000_0000, irq_status_reg};
        ADDR_IRQ_ENABLE: rdata_o <= {29'h0000_0000, irq_enable_reg};
        ADDR_ENGINE: rdata_o <= {16'h0000, cur_event_reg, 1'h0, qcount_reg, 2'h0, state_reg};
        default: rdata_o <= '0;
      endcase
    end
    else
      rdata_o <= '0;
  end
endmodule
`default_nettype wire

// file: test/esa_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module esa_checker
  import evmon_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic event_valid_i,
  input wire logic seq_start_o,
  input wire logic [7:0] seq_id_o,
  input wire logic seq_done_i,
  input wire logic irq_o
);
  logic run_reg;
  // a sequence is out from its start pulse until the runner reports done
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      run_reg <= 1'b0;
    else
      run_reg <= seq_start_o | (run_reg & ~seq_done_i);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data outside read slot");
  a_unmapped_read: assert property (rd_i && addr_i > ADDR_ENGINE |=> rdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_start_pulse: assert property (seq_start_o |=> !seq_start_o)
    else $error("start pulse too long");
  a_id_holds: assert property (!seq_start_o |-> $stable(seq_id_o))
    else $error("sequence id moved");
  a_one_running: assert property (seq_start_o |-> !run_reg)
    else $error("start while sequence running");
  a_unknown_code: assert property (wr_i && addr_i == ADDR_COMMAND && wdata_i[15:8] != 8'h8C ##2
    rd_i && addr_i == ADDR_RESULT |=> rdata_o[2:0] == STATUS_UNKNOWN_COMMAND)
    else $error("unknown command accepted");
  a_irq_rise_cause: assert property ($rose(irq_o) |-> $past(wr_i) || $past(event_valid_i) ||
    seq_start_o || $past(seq_start_o))
    else $error("interrupt without cause");
  a_irq_fall_write: assert property ($fell(irq_o) |-> $past(wr_i))
    else $error("interrupt fell without write");
endmodule
bind event_sequence_association esa_checker u_esa_checker (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .event_valid_i, .seq_start_o, .seq_id_o, .seq_done_i, .irq_o);
`default_nettype wire

// file: test/seq_runner_model.sv
`timescale 1ns/1ps
`default_nettype none
module seq_runner_model
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [7:0] delay_i,
  output logic done_o
);
  logic [7:0] cnt_reg;
  logic busy_reg;
  // delay of at least one cycle, so done never meets its own start
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      cnt_reg <= 8'h00;
      busy_reg <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= busy_reg & (cnt_reg == 8'h01);
      busy_reg <= start_i | (busy_reg & (cnt_reg != 8'h01));
      cnt_reg <= start_i ? delay_i : cnt_reg - 8'h01;
    end
endmodule
`default_nettype wire

// file: test/event_sequence_association_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error %0t: got %h exp %h", $time, a, b); end end
module event_sequence_association_tb
  import evmon_pkg::*;
;
  logic clk_i, rst_n_i, wr_i, rd_i, event_valid_i, seq_done_i, seq_start_o, irq_o, rd_seen;
  logic [3:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [7:0] event_code_i, seq_id_o, dly, rs;
  logic [31:0] rq[$];
  logic [7:0] sq[$];
  int n_mismatch, cmp_count, seed;
  event_sequence_association u_event_sequence_association (.clk_i, .rst_n_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .event_valid_i, .event_code_i, .seq_start_o, .seq_id_o, .seq_done_i, .irq_o);
  seq_runner_model u_seq_runner_model (.clk_i, .rst_n_i, .start_i(seq_start_o), .delay_i(dly),
    .done_o(seq_done_i));
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  task automatic cmd(input logic [31:0] p, input logic [15:0] c, input status_t s);
    wr(ADDR_PARAM, p);
    wr(ADDR_COMMAND, {16'h0000, c});
    rd(ADDR_RESULT, {29'h0000_0000, s});
  endtask
  task automatic ev(input logic [7:0] c);
    @(posedge clk_i);
    event_valid_i <= 1'b1;
    event_code_i <= c;
    @(posedge clk_i);
    event_valid_i <= 1'b0;
  endtask
  // bounded wait until every expected start was seen
  task automatic drain;
    for (int i = 0; i < 2000 && sq.size() > 0; i++)
      @(posedge clk_i);
    repeat (8) @(posedge clk_i);
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clk_i)
    rd_seen <= rd_i;
  always @(negedge clk_i)
  begin
    if (rd_seen)
      `CHK(rdata_o, rq.pop_front())
    if (seq_start_o)
      `CHK(seq_id_o, sq.pop_front())
  end
  initial
  begin
    #200_000;
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    seed = 85759;
    {rst_n_i, wr_i, rd_i, event_valid_i, rd_seen} = '0;
    addr_i = 4'h0;
    wdata_i = 32'h0000_0000;
    event_code_i = 8'h00;
    dly = 8'h28;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cmd(32'h0211_0101, CMD_SET_ASSOC, STATUS_OK);
    cmd(32'h0233_0103, CMD_SET_ASSOC, STATUS_OK);
    cmd(32'h00A5_0105, CMD_SET_ASSOC, STATUS_OK);
    cmd(32'h0277_0103, CMD_SET_ASSOC, STATUS_ALREADY_IN_USE);
    cmd(32'h0200_0108, CMD_SET_ASSOC, STATUS_INVALID_ARGUMENT);
    cmd(32'h0700_0106, CMD_SET_ASSOC, STATUS_OUT_OF_RANGE);
    cmd(32'h0200_0002, CMD_SET_ASSOC, STATUS_NO_ENTRY);
    cmd(32'h0000_0003, CMD_GET_ASSOC, STATUS_OK);
    rd(ADDR_RESPONSE, 32'h0233_0103);
    cmd(32'h0000_0000, 16'h1234, STATUS_UNKNOWN_COMMAND);
    rd(4'hF, 32'h0000_0000);
    sq = '{8'h11, 8'h33, 8'hA5};
    ev(8'h02);
    ev(8'h00);
    cmd(32'h0211_0001, CMD_SET_ASSOC, STATUS_OK);
    cmd(32'h0211_0101, CMD_SET_ASSOC, STATUS_SLOT_BUSY);
    drain();
    cmd(32'h0211_0101, CMD_SET_ASSOC, STATUS_OK);
    // engine still busy with the last start: four wait, the last two have no room
    sq = '{8'hA5, 8'hA5, 8'hA5, 8'hA5};
    repeat (6) ev(8'h00);
    drain();
    rd(ADDR_IRQ_STATUS, 32'h0000_0007);
    wr(ADDR_IRQ_ENABLE, 32'h0000_0002);
    rd(ADDR_IRQ_ENABLE, 32'h0000_0002);
    // irq follows registers updated on the edge, so look half a cycle later
    @(negedge clk_i);
    `CHK(irq_o, 1'b1)
    wr(ADDR_IRQ_CLEAR, 32'h0000_0007);
    @(negedge clk_i);
    `CHK(irq_o, 1'b0)
    rd(ADDR_IRQ_STATUS, 32'h0000_0000);
    rs = 8'($random(seed));
    cmd({8'h04, rs, 8'h01, 8'h07}, CMD_SET_ASSOC, STATUS_OK);
    cmd(32'h0000_0007, CMD_GET_ASSOC, STATUS_OK);
    rd(ADDR_RESPONSE, {8'h04, rs, 8'h01, 8'h07});
    ev(8'h09);
    sq.push_back(rs);
    ev(8'h04);
    drain();
    // still waiting on slot 7, event 4 current, queue empty
    rd(ADDR_ENGINE, 32'h0000_0402);
    repeat (2) @(posedge clk_i);
    `CHK(sq.size(), 0)
    report_and_stop();
  end
endmodule
`default_nettype wire
